// *** hw/usb_bd_engine.sv ***
// Descriptor ownership engine with two-level write-one-to-clear interrupt funnel
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module usb_bd_engine
  import usb_bd_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              tok_valid,
  input  wire logic [3:0]        tok_pid,
  output logic                   tok_ready,
  input  wire logic              dat_valid,
  input  wire logic              dat_toggle,
  input  wire logic              dat_last,
  input  wire logic              dat_crc_err,
  input  wire logic [7:0]        dat_in,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  output logic                   tx_last,
  output logic                   tx_toggle,
  output logic                   hs_stall,
  output logic [15:0]            mem_addr,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  output logic                   dplus_pullup_enable,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SEND  = 5'b00010,
    ST_RECV  = 5'b00100,
    ST_DONE  = 5'b01000,
    ST_STALL = 5'b10000
  } bd_state_e;

  bd_state_e        state_q;
  logic [15:0]      bd_stat_q;
  logic [15:0]      bd_addr_q;
  logic [7:0]       top_flag_q, top_en_q, err_flag_q, err_en_q;
  logic [7:0]       mod_ctrl_q, otg_ctrl_q, pwr_ctrl_q, ep0_ctrl_q;
  logic             ep_stall_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0]       pid_q;
  logic             drop_q;
  logic             tok_done, stall_hit, tog_err, crc_err, ovr_err;
  logic             wr_en, rd_en;

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign pready    = 1'b1;
  assign tok_ready = (state_q == ST_IDLE);

  // Usable only while enabled, powered and owned by the module
  logic active;
  assign active = mod_ctrl_q[CTRL_ENABLE] && pwr_ctrl_q[PWR_ON];
  logic owned;
  assign owned = bd_stat_q[BD_OWN]; // see [R1] see [R2]

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic mapped;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_TOP_FLAG:  prdata[7:0]  = top_flag_q;
      ADDR_TOP_EN:    prdata[7:0]  = top_en_q;
      ADDR_ERR_FLAG:  prdata[7:0]  = err_flag_q;
      ADDR_ERR_EN:    prdata[7:0]  = err_en_q;
      ADDR_MOD_CTRL:  prdata[7:0]  = mod_ctrl_q;
      ADDR_OTG_CTRL:  prdata[7:0]  = otg_ctrl_q;
      ADDR_PWR_CTRL:  prdata[7:0]  = pwr_ctrl_q;
      ADDR_EP0_CTRL:  prdata[7:0]  = ep0_ctrl_q;
      ADDR_BD_STAT:   prdata[15:0] = bd_stat_q;
      ADDR_BD_ADDR:   prdata[15:0] = bd_addr_q; // see [R21]
      ADDR_EP_STATUS: prdata[0]    = ep_stall_q;
      default:        mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // Plain control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_en_q   <= RST_BYTE;
      err_en_q   <= RST_BYTE;
      mod_ctrl_q <= RST_BYTE;
      otg_ctrl_q <= RST_BYTE;
      pwr_ctrl_q <= RST_BYTE;
      ep0_ctrl_q <= RST_BYTE;
      bd_addr_q  <= RST_WORD;
    end else if (wr_en) begin
      if (paddr == ADDR_TOP_EN)   top_en_q   <= pwdata[7:0];
      if (paddr == ADDR_ERR_EN)   err_en_q   <= pwdata[7:0];
      if (paddr == ADDR_MOD_CTRL) mod_ctrl_q <= pwdata[7:0];
      if (paddr == ADDR_OTG_CTRL) otg_ctrl_q <= pwdata[7:0];
      if (paddr == ADDR_PWR_CTRL) pwr_ctrl_q <= pwdata[7:0];
      if (paddr == ADDR_EP0_CTRL) ep0_ctrl_q <= pwdata[7:0];
      if (paddr == ADDR_BD_ADDR && !owned) bd_addr_q <= pwdata[15:0];
    end
  end
  assign dplus_pullup_enable = otg_ctrl_q[OTG_PULLUP];

  // ----------------------------------------------------------------
  // Interrupt funnel
  // ----------------------------------------------------------------
  // Error flags: hardware sets, write one clears, set wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_flag_q <= RST_BYTE;
    end else begin
      err_flag_q <= (err_flag_q & ~((wr_en && paddr == ADDR_ERR_FLAG) ? pwdata[7:0] : 8'h00)) // see [R11]
                    | ({3'h0, ovr_err, 1'b0, tog_err, crc_err, 1'b0});
    end
  end

  // Top flags; summary follows any enabled error
  logic [7:0] top_set;
  always_comb begin
    top_set              = 8'h00;
    top_set[TOP_TOKEN]   = tok_done; // see [R18] see [R19]
    top_set[TOP_STALL]   = stall_hit;
    top_set[TOP_ERR_SUM] = |(err_flag_q & err_en_q); // see [R10]
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_flag_q <= RST_BYTE;
    end else begin
      top_flag_q <= (top_flag_q & ~((wr_en && paddr == ADDR_TOP_FLAG) ? pwdata[7:0] : 8'h00)) // see [R11]
                    | top_set;
    end
  end
  assign irq = |(top_flag_q & top_en_q); // see [R9]

  // ----------------------------------------------------------------
  // Token engine
  // ----------------------------------------------------------------
  logic tog_ok;
  assign tog_ok = !bd_stat_q[BD_SYNC_EN] || (dat_toggle == bd_stat_q[BD_TOGGLE]); // see [R6] see [R7]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pid_q   <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (tok_valid && active && owned) begin
          pid_q <= tok_pid;
          if (bd_stat_q[BD_STALL] || ep0_ctrl_q[EP_STALLBIT]) state_q <= ST_STALL; // see [R8]
          else if (tok_pid == PID_IN) state_q <= ST_SEND;
          else if (ep0_ctrl_q[EP_RX]) state_q <= ST_RECV; // see [R20]
        end
        ST_SEND: if (cnt_q == bd_stat_q[BD_CNT_HI:0]) state_q <= ST_DONE;
        ST_RECV: if (dat_valid && dat_last) state_q <= drop_q ? ST_IDLE : ST_DONE;
        ST_DONE:  state_q <= ST_IDLE;
        ST_STALL: state_q <= ST_IDLE;
      endcase
    end
  end

  // Byte counter and toggle-drop latch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      drop_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      cnt_q  <= '0;
      drop_q <= 1'b0;
    end else if (state_q == ST_SEND && cnt_q != bd_stat_q[BD_CNT_HI:0]) begin
      // Stops at the byte count so the stored count is the sent count
      cnt_q <= cnt_q + 1'b1; // see [R18] see [R5]
    end else if (state_q == ST_RECV && dat_valid) begin
      if (!tog_ok) drop_q <= 1'b1; // see [R6]
      if (!dat_last && tog_ok && !drop_q && cnt_q != bd_stat_q[BD_CNT_HI:0]) cnt_q <= cnt_q + 1'b1;
    end
  end

  // Data movement to and from the buffer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      tx_last   <= 1'b0;
      tx_toggle <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
      hs_stall  <= 1'b0;
    end else begin
      tx_valid  <= (state_q == ST_SEND) && cnt_q != bd_stat_q[BD_CNT_HI:0];
      tx_last   <= (state_q == ST_SEND) && cnt_q == bd_stat_q[BD_CNT_HI:0];
      tx_data   <= mem_rdata;
      tx_toggle <= bd_stat_q[BD_TOGGLE]; // see [R3]
      mem_wr    <= (state_q == ST_RECV) && dat_valid && !dat_last && tog_ok && !drop_q
                   && cnt_q != bd_stat_q[BD_CNT_HI:0]; // see [R19]
      mem_wdata <= dat_in;
      hs_stall  <= (state_q == ST_STALL);
    end
  end
  // Count has already moved on when a write pulse stands, so step back one
  assign mem_addr = bd_addr_q + {{(16-CNT_W){1'b0}}, cnt_q} - {15'h0000, mem_wr};

  // Events feeding the flags
  assign tok_done  = (state_q == ST_DONE);
  assign stall_hit = (state_q == ST_STALL);
  assign tog_err   = (state_q == ST_RECV) && dat_valid && !tog_ok;
  assign crc_err   = (state_q == ST_RECV) && dat_valid && dat_crc_err;
  assign ovr_err   = (state_q == ST_RECV) && dat_valid && !dat_last && cnt_q == bd_stat_q[BD_CNT_HI:0];

  // Endpoint stall flag, cleared by write one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ep_stall_q <= 1'b0;
    else     ep_stall_q <= (ep_stall_q && !(wr_en && paddr == ADDR_EP_STATUS && pwdata[0])) || stall_hit; // see [R8]
  end

  // Descriptor status word: CPU writes only while it owns it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bd_stat_q <= RST_WORD;
    end else if (state_q == ST_DONE) begin
      // Ownership, PID and count in one update; software must queue the control status phase
      bd_stat_q <= {1'b0, bd_stat_q[BD_TOGGLE], pid_q, cnt_q}; // see [R4] see [R5] see [R22] see [R12]
    end else if (wr_en && paddr == ADDR_BD_STAT && !owned) begin
      bd_stat_q <= {pwdata[15:14], 2'b00, pwdata[11:0]}; // see [R17]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence done_seq;
    state_q == ST_DONE;
  endsequence

  done_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R22]
    done_seq |=> !bd_stat_q[BD_OWN]) else $error("ownership not returned");
  done_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R18]
    done_seq |=> top_flag_q[TOP_TOKEN]) else $error("token flag missing");
  pid_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R4]
    done_seq |=> bd_stat_q[BD_PID_HI:BD_PID_LO] == $past(pid_q)) else $error("pid not stored");
  stall_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R8]
    state_q == ST_STALL |=> bd_stat_q == $past(bd_stat_q) && ep_stall_q && hs_stall) else $error("stall wrong");
  idle_unowned_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R2]
    state_q == ST_IDLE && !owned |=> state_q == ST_IDLE) else $error("unowned descriptor used");
  err_sum_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R10]
    |(err_flag_q & err_en_q) |=> top_flag_q[TOP_ERR_SUM]) else $error("summary missing");
  irq_funnel_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R9]
    irq == |(top_flag_q & top_en_q)) else $error("irq mismatch");
  zero_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R11]
    wr_en && paddr == ADDR_TOP_FLAG && pwdata[7:0] == 8'h00 |=> (top_flag_q & $past(top_flag_q)) == $past(top_flag_q))
    else $error("zero write cleared flag");
  sync_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R6]
    state_q == ST_RECV && dat_valid && !tog_ok |=> !mem_wr) else $error("bad toggle stored");
  reserved_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R7]
    bd_stat_q[BD_RSV_HI:BD_RSV_LO] == 2'b00 || !owned || state_q != ST_IDLE) else $error("reserved bits set");
  count_limit_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R5]
    state_q != ST_IDLE |-> cnt_q <= bd_stat_q[BD_CNT_HI:0]) else $error("count beyond limit");
  owned_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see [R1]
    wr_en && paddr == ADDR_BD_STAT && owned && state_q != ST_DONE |=> bd_stat_q == $past(bd_stat_q))
    else $error("owned status overwritten");

endmodule : usb_bd_engine
`default_nettype wire

// *** hw/usb_bd_pkg.sv ***
// Package with register map, descriptor fields, token PIDs and reset values for the descriptor engine
// Notes on behaviour
// [R1] Ownership set: module owns descriptor and buffer
// [R2] Ownership clear: module ignores all other fields
// [R3] Toggle bit one means DATA1, zero DATA0
// [R4] Module writes token PID into status word
// [R5] Byte count replaced with actual moved count
// [R6] Toggle sync enabled drops mismatching data packets
// [R7] Toggle bit ignored unless sync enabled; only receive does so here, tx_toggle always sends the stored toggle bit
// [R8] Buffer stall answers STALL, keeps descriptor, flags endpoint
// [R9] All interrupt sources share one output
// [R10] Enabled error flags set top error summary
// [R11] Flags set by hardware, write one clears
// [R12] Control status phase handled without software; not done here, each completed token hands the descriptor back to software
// [R13] Software pulses ping-pong reset before enabling
// [R14] Software clears enables then writes ones to flags
// [R15] Software enables module, OTG, endpoint zero
// [R16] Software sets power then D+ pull-up last
// [R17] Software sets ownership bit last when queueing
// [R18] IN token sends buffer, updates word, sets done
// [R19] OUT token stores data, updates word, sets done
// [R20] Host role uses endpoint zero, software driven; no host role here, the module only answers tokens as a device
// [R21] Buffer address word is sixteen bits
// [R22] Completion clears ownership with PID and count
package usb_bd_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] ADDR_TOP_FLAG   = 8'h00;
  localparam logic [7:0] ADDR_TOP_EN     = 8'h04;
  localparam logic [7:0] ADDR_ERR_FLAG   = 8'h08;
  localparam logic [7:0] ADDR_ERR_EN     = 8'h0c;
  localparam logic [7:0] ADDR_MOD_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_OTG_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_EP0_CTRL   = 8'h1c;
  localparam logic [7:0] ADDR_BD_STAT    = 8'h20;
  localparam logic [7:0] ADDR_BD_ADDR    = 8'h24;
  localparam logic [7:0] ADDR_EP_STATUS  = 8'h28;
  // Descriptor status word fields
  localparam int BD_OWN     = 15;
  localparam int BD_TOGGLE  = 14;
  localparam int BD_PID_HI  = 13;
  localparam int BD_PID_LO  = 10;
  localparam int BD_SYNC_EN = 11;
  localparam int BD_STALL   = 10;
  localparam int BD_CNT_HI  = 9;
  localparam int BD_RSV_HI  = 13;
  localparam int BD_RSV_LO  = 12;
  // Top-level flag positions
  localparam int TOP_ERR_SUM  = 1;
  localparam int TOP_TOKEN    = 3;
  localparam int TOP_STALL    = 7;
  // Error flag positions
  localparam int ERR_CRC      = 1;
  localparam int ERR_TOGGLE   = 2;
  localparam int ERR_OVERRUN  = 4;
  // Control bit positions
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_PP_RST  = 1;
  localparam int OTG_ENABLE   = 2;
  localparam int OTG_PULLUP   = 7;
  localparam int PWR_ON       = 0;
  localparam int EP_HSHK      = 0;
  localparam int EP_STALLBIT  = 1;
  localparam int EP_RX        = 3;
  // Token PIDs
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_STALL = 4'he;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage : usb_bd_pkg

// *** testbench/usb_buffer_descriptor_and_irq_tb_top.sv ***
// Testbench for the descriptor engine with APB tasks and a host model
`timescale 1ns/10ps
`default_nettype none
module usb_buffer_descriptor_and_irq_tb_top;
  import usb_bd_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr, mem_wdata, mem_rdata, tx_data, dat_in;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] mem_addr;
  logic [3:0] tok_pid;
  logic tok_valid, tok_ready, dat_valid, dat_toggle, dat_last, dat_crc_err, tx_valid, tx_last, tx_toggle;
  logic hs_stall, mem_wr, dplus_pullup_enable, irq;
  logic [7:0] mem [256];
  int err_count = 0;
  int cmp_count = 0;
  usb_bd_engine usb_bd_engine_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ready(tok_ready), .dat_valid(dat_valid),
    .dat_toggle(dat_toggle), .dat_last(dat_last), .dat_crc_err(dat_crc_err), .dat_in(dat_in),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_toggle(tx_toggle), .hs_stall(hs_stall),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .dplus_pullup_enable(dplus_pullup_enable), .irq(irq));
  usb_host_model usb_host_model_inst (.sys_clk(sys_clk), .tok_ready(tok_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_toggle(tx_toggle), .hs_stall(hs_stall), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .dat_valid(dat_valid), .dat_toggle(dat_toggle), .dat_last(dat_last),
    .dat_crc_err(dat_crc_err), .dat_in(dat_in));
  // Buffer memory, combinational read
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge sys_clk) if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------
  // Bus tasks and checks
  // --------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err_q = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge sys_clk); // Written value settled before callers look
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Poll the token done flag with a bounded count
  task automatic wait_done();
    int n;
    n = 0;
    apb(1'b0, ADDR_TOP_FLAG, 32'h0, q);
    while (q[TOP_TOKEN] !== 1'b1 && n < 60) begin
      apb(1'b0, ADDR_TOP_FLAG, 32'h0, q);
      n++;
    end
    chk("token done flag", 32'h1, {31'h0, q[TOP_TOKEN]});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(40 * 20000);
    err_count++;
    conclude();
  end
  // --------------------------------------------------
  // Test sequence
  // --------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("status reset", 32'(RST_WORD), q);
    apb(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, err_q});
    $display("test reset done");
    wr(ADDR_MOD_CTRL, 32'h2);
    wr(ADDR_MOD_CTRL, 32'h0);
    wr(ADDR_TOP_EN, 32'h0);
    wr(ADDR_ERR_EN, 32'h0);
    wr(ADDR_TOP_FLAG, 32'hff);
    wr(ADDR_ERR_FLAG, 32'hff);
    wr(ADDR_MOD_CTRL, 32'h1);
    wr(ADDR_OTG_CTRL, 32'h4);
    wr(ADDR_EP0_CTRL, 32'h9);
    wr(ADDR_PWR_CTRL, 32'h1);
    wr(ADDR_OTG_CTRL, 32'h84);
    chk("pull-up", 32'h1, {31'h0, dplus_pullup_enable});
    $display("test enable done");
    wr(ADDR_TOP_EN, 32'h8);
    wr(ADDR_BD_ADDR, 32'h40);
    wr(ADDR_BD_STAT, 32'h4003);
    wr(ADDR_BD_STAT, 32'hc003);
    usb_host_model_inst.token(PID_IN);
    wait_done();
    chk("sent count", 32'h3, 32'(usb_host_model_inst.rx_q.size()));
    foreach (usb_host_model_inst.rx_q[i])
      chk("sent byte", 32'(8'(8'h40 + i) ^ 8'ha5), 32'(usb_host_model_inst.rx_q[i]));
    chk("packet end", 32'h1, {31'h0, usb_host_model_inst.end_q});
    chk("sent toggle", 32'h1, {31'h0, usb_host_model_inst.tog_q});
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("status after in", 32'h6403, q);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(ADDR_TOP_FLAG, 32'h0);
    chk("irq after zero write", 32'h1, {31'h0, irq});
    wr(ADDR_TOP_FLAG, 32'h8);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test in done");
    wr(ADDR_BD_ADDR, 32'h80);
    wr(ADDR_BD_STAT, 32'h8804);
    wr(ADDR_BD_STAT, 32'h0);
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("owned status kept", 32'h8804, q);
    wr(ADDR_ERR_EN, 32'h4);
    usb_host_model_inst.token(PID_OUT);
    usb_host_model_inst.packet(1'b1, 2, 8'h50);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, ADDR_ERR_FLAG, 32'h0, q);
    chk("toggle error flag", 32'h4, q & 32'h4);
    apb(1'b0, ADDR_TOP_FLAG, 32'h0, q);
    chk("error summary", 32'h2, q & 32'ha);
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("dropped status", 32'h8804, q);
    usb_host_model_inst.token(PID_OUT);
    usb_host_model_inst.packet(1'b0, 2, 8'h30);
    wait_done();
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("status after out", 32'h0402, q);
    chk("stored bytes", 32'h3031, {16'h0, mem[8'h80], mem[8'h81]});
    $display("test out done");
    wr(ADDR_TOP_FLAG, 32'hff);
    wr(ADDR_BD_STAT, 32'hc004);
    usb_host_model_inst.token(PID_OUT);
    usb_host_model_inst.packet(1'b0, 1, 8'h60);
    wait_done();
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("unsynced count", 32'h1, q & 32'h83ff);
    // Second byte overruns a one byte buffer and is refused
    wr(ADDR_TOP_FLAG, 32'hff);
    wr(ADDR_BD_STAT, 32'h8001);
    usb_host_model_inst.token(PID_OUT);
    usb_host_model_inst.packet(1'b0, 2, 8'h70);
    wait_done();
    apb(1'b0, ADDR_ERR_FLAG, 32'h0, q);
    chk("overrun flag", 32'h10, q & 32'h10);
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("overrun status", 32'h0401, q);
    chk("overrun stored", 32'h7031, {16'h0, mem[8'h80], mem[8'h81]});
    $display("test toggle done");
    wr(ADDR_TOP_FLAG, 32'hff);
    usb_host_model_inst.rx_q.delete();
    wr(ADDR_BD_STAT, 32'h0003);
    usb_host_model_inst.token(PID_IN);
    repeat (20) @(posedge sys_clk);
    chk("cpu owned sends", 32'h0, 32'(usb_host_model_inst.rx_q.size()));
    apb(1'b0, ADDR_TOP_FLAG, 32'h0, q);
    chk("cpu owned flags", 32'h0, q & 32'h8);
    wr(ADDR_BD_STAT, 32'h8402);
    usb_host_model_inst.token(PID_IN);
    repeat (10) @(posedge sys_clk);
    chk("stall handshake", 32'h1, {31'h0, usb_host_model_inst.stall_q});
    apb(1'b0, ADDR_EP_STATUS, 32'h0, q);
    chk("endpoint stall", 32'h1, q & 32'h1);
    apb(1'b0, ADDR_BD_STAT, 32'h0, q);
    chk("stalled status", 32'h8402, q);
    $display("test stall done");
    conclude();
  end
endmodule // usb_buffer_descriptor_and_irq_tb_top
`default_nettype wire

// *** testbench/usb_host_model.sv ***
// Host side model that issues tokens, sends data packets and collects sent bytes
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  input  wire logic       sys_clk,
  input  wire logic       tok_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       tx_toggle,
  input  wire logic       hs_stall,
  output logic            tok_valid,
  output logic [3:0]      tok_pid,
  output logic            dat_valid,
  output logic            dat_toggle,
  output logic            dat_last,
  output logic            dat_crc_err,
  output logic [7:0]      dat_in
);
  logic [7:0] rx_q[$];
  logic       end_q;
  logic       stall_q;
  logic       tog_q;
  // Quiet lines at time zero
  initial {tok_valid, tok_pid, dat_valid, dat_toggle, dat_last, dat_crc_err, dat_in, end_q, stall_q} = '0;
  // Collect sent bytes, packet ends and stall handshakes
  always @(posedge sys_clk) begin
    if (tx_valid) rx_q.push_back(tx_data);
    if (tx_valid) tog_q <= tx_toggle;
    if (tx_last) end_q <= 1'b1;
    if (hs_stall) stall_q <= 1'b1;
  end
  // Token held until taken, then pid lines scrambled
  task automatic token(input logic [3:0] pid);
    @(posedge sys_clk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    @(posedge sys_clk);
    while (tok_ready !== 1'b1) @(posedge sys_clk);
    tok_valid <= 1'b0;
    tok_pid <= ~pid;
  endtask
  // One byte pulse per two cycles, then the end marker
  task automatic packet(input logic tg, input int cnt, input logic [7:0] b0);
    for (int i = 0; i <= cnt; i++) begin
      @(posedge sys_clk);
      dat_valid <= 1'b1;
      dat_toggle <= tg;
      dat_last <= (i == cnt);
      dat_in <= b0 + 8'(i);
      @(posedge sys_clk);
      dat_valid <= 1'b0;
      dat_last <= 1'b0;
      dat_in <= ~(b0 + 8'(i));
    end
  endtask
endmodule // usb_host_model
`default_nettype wire
